// ==== incr_or_shift_pkg.sv ====
package incr_or_shift_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int PC_W = 15;
  localparam int INSTR_W = 14;
  localparam int LATCH_W = 7;
  localparam int JUMP_IMM_W = 11;
  localparam int CLK_PER_ICYC = 2;
  localparam int JUMP_ICYC = 2;
  localparam int SKIP_ICYC = 2;

  localparam int DEST_POS = 7;
  localparam int FILE_LSB = 0;
  localparam int IMM_LSB = 0;
  localparam int OPC_LSB = 8;
  localparam int JOPC_LSB = 11;
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;

  localparam logic DEST_ACC = 1'b0;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;

  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_OR_OPND = 6'h04;
  localparam logic [5:0] OPC_SHL = 6'h35;
  localparam logic [5:0] OPC_OR_IMM = 6'h38;
  localparam logic [2:0] OPC_JUMP = 3'h5;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC_SKIP = 3'b001,
    OP_JUMP = 3'b010,
    OP_OR_IMM = 3'b011,
    OP_INC = 3'b100,
    OP_OR_OPND = 3'b101,
    OP_SHL = 3'b110
  } op_t;

  function automatic op_t op_decode(input logic [INSTR_W-1:0] w);
    op_t op;
    op = OP_NONE;
    if (w[INSTR_W-1:JOPC_LSB] == OPC_JUMP) begin
      op = OP_JUMP;
    end else begin
      unique case (w[INSTR_W-1:OPC_LSB])
        OPC_INC_SKIP: op = OP_INC_SKIP;
        OPC_INC: op = OP_INC;
        OPC_OR_OPND: op = OP_OR_OPND;
        OPC_SHL: op = OP_SHL;
        OPC_OR_IMM: op = OP_OR_IMM;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction : op_decode
endpackage : incr_or_shift_pkg

// ==== data_file_mem.sv ====
`timescale 1ns/100ps
module data_file_mem
  import incr_or_shift_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [FILE_ADDR_W-1:0] rd_addr,
  input wire logic wr_en,
  input wire logic [FILE_ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  generate
    if (DEPTH != (1 << FILE_ADDR_W)) begin : g_bad_depth
      $error("data_file_mem: DEPTH must match the operand index range");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
  } mem_t;

  mem_t q;
  mem_t d;

  // Read data always comes out of a register
  always_comb begin
    d = q;
    d.rdata = q.mem[rd_addr];
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q.rdata <= ACC_RESET;
      q.mem <= d.mem;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rdata;
endmodule : data_file_mem

// ==== exec_alu.sv ====
`timescale 1ns/100ps
module exec_alu
  import incr_or_shift_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] opnd,
  output logic [DATA_W-1:0] result,
  output logic to_acc,
  output logic to_file,
  output logic nil_upd,
  output logic nil_val,
  output logic shout_upd,
  output logic shout_val,
  output logic skip_next
);
  op_t op;
  logic dest;
  logic [DATA_W-1:0] imm;

  always_comb begin
    op = op_decode(instr);
    dest = instr[DEST_POS];
    imm = instr[IMM_LSB +: DATA_W];
    result = ACC_RESET;
    to_acc = 1'b0;
    to_file = 1'b0;
    nil_upd = 1'b0;
    shout_upd = 1'b0;
    shout_val = 1'b0;
    skip_next = 1'b0;
    unique case (op)
      OP_INC_SKIP: begin
        result = opnd + ONE;
        skip_next = (result == ACC_RESET);
      end
      OP_INC: begin
        result = opnd + ONE;
        nil_upd = 1'b1;
      end
      OP_OR_OPND: begin
        result = acc | opnd;
        nil_upd = 1'b1;
      end
      OP_SHL: begin
        result = {opnd[DATA_W-2:0], 1'b0};
        shout_val = opnd[DATA_W-1];
        shout_upd = 1'b1;
        nil_upd = 1'b1;
      end
      OP_OR_IMM: begin
        result = acc | imm;
        nil_upd = 1'b1;
      end
      default: begin
        result = ACC_RESET;
      end
    endcase
    if (op == OP_INC_SKIP || op == OP_INC || op == OP_OR_OPND ||
        op == OP_SHL) begin
      to_acc = (dest == DEST_ACC);
      to_file = (dest != DEST_ACC);
    end else if (op == OP_OR_IMM) begin
      to_acc = 1'b1;
    end
    nil_val = (result == ACC_RESET);
  end
endmodule : exec_alu

// ==== incr_or_shift_core.sv ====
`timescale 1ns/100ps
module incr_or_shift_core
  import incr_or_shift_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [LATCH_W-1:0] program_counter_upper_latch,
  input wire logic host_wr_en,
  input wire logic [FILE_ADDR_W-1:0] host_wr_addr,
  input wire logic [DATA_W-1:0] host_wr_data,
  output logic instr_take,
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] accumulator_reg,
  output logic result_nil_flag,
  output logic shift_out_bit,
  output logic icycle_done,
  output logic unknown_instr,
  output logic file_wr_en,
  output logic [FILE_ADDR_W-1:0] file_wr_addr,
  output logic [DATA_W-1:0] file_wr_data,
  output logic host_wr_ack
);
  generate
    if (FILE_DEPTH != (1 << FILE_ADDR_W)) begin : g_bad_depth
      $error("incr_or_shift_core: FILE_DEPTH must be 128");
    end
    if (CLK_PER_ICYC != 2) begin : g_bad_icyc
      $error("incr_or_shift_core: sequencer serves two clocks a cycle");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } st_t;

  typedef struct packed {
    st_t st;
    logic kill;
    logic [INSTR_W-1:0] ir;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] acc;
    logic nil;
    logic shout;
    logic take;
    logic done;
    logic unknown;
    logic wr_en;
    logic [FILE_ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic host_ack;
  } core_t;

  core_t q;
  core_t d;

  logic [FILE_ADDR_W-1:0] mem_rd_addr;
  logic mem_wr_en;
  logic [FILE_ADDR_W-1:0] mem_wr_addr;
  logic [DATA_W-1:0] mem_wr_data;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] alu_result;
  logic alu_to_acc;
  logic alu_to_file;
  logic alu_nil_upd;
  logic alu_nil_val;
  logic alu_shout_upd;
  logic alu_shout_val;
  logic alu_skip;
  logic core_wr;
  op_t ex_op;

  data_file_mem #(
    .DEPTH(FILE_DEPTH)
  ) data_file_mem_i (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rd_addr(mem_rd_addr),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_data(opnd)
  );

  exec_alu exec_alu_i (
    .instr(q.ir),
    .acc(q.acc),
    .opnd(opnd),
    .result(alu_result),
    .to_acc(alu_to_acc),
    .to_file(alu_to_file),
    .nil_upd(alu_nil_upd),
    .nil_val(alu_nil_val),
    .shout_upd(alu_shout_upd),
    .shout_val(alu_shout_val),
    .skip_next(alu_skip)
  );

  // Operand read is issued as the word is taken
  always_comb begin
    mem_rd_addr = instr_word[FILE_LSB +: FILE_ADDR_W];
    ex_op = op_decode(q.ir);
    core_wr = (q.st == ST_EXEC) && !q.kill && alu_to_file;
    mem_wr_en = core_wr || host_wr_en;
    mem_wr_addr = host_wr_addr;
    mem_wr_data = host_wr_data;
    if (core_wr) begin
      mem_wr_addr = q.ir[FILE_LSB +: FILE_ADDR_W];
      mem_wr_data = alu_result;
    end
  end

  // Sequencer: two clocks per instruction cycle
  always_comb begin
    d = q;
    d.take = 1'b0;
    d.done = 1'b0;
    d.unknown = 1'b0;
    d.wr_en = 1'b0;
    d.host_ack = host_wr_en && !core_wr;
    unique case (q.st)
      ST_FETCH: begin
        if (instr_valid) begin
          d.ir = instr_word;
          d.take = 1'b1;
          d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        d.done = 1'b1;
        d.st = ST_FETCH;
        if (q.kill) begin
          // Discarded slot behaves as a no-op
          // A skipped word steps the counter, the flush slot holds it
          d.kill = 1'b0;
          d.pc = q.pc + (q.take ? PC_W'(1) : PC_W'(0));
        end else begin
          d.unknown = (ex_op == OP_NONE);
          if (alu_to_acc) begin
            d.acc = alu_result;
          end
          if (alu_nil_upd) begin
            d.nil = alu_nil_val;
          end
          if (alu_shout_upd) begin
            d.shout = alu_shout_val;
          end
          if (core_wr) begin
            d.wr_en = 1'b1;
            d.wr_addr = mem_wr_addr;
            d.wr_data = mem_wr_data;
          end
          if (ex_op == OP_JUMP) begin
            d.pc = {program_counter_upper_latch[LATCH_HI:LATCH_LO],
                    q.ir[JUMP_IMM_W-1:0]};
            d.st = ST_FLUSH;
          end else begin
            d.pc = q.pc + PC_W'(1);
            d.kill = alu_skip;
          end
        end
      end
      ST_FLUSH: begin
        // Second jump cycle: nothing taken, counter held
        d.st = ST_EXEC;
        d.kill = 1'b1;
      end
      default: begin
        d.st = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q.st <= ST_FETCH;
      q.kill <= 1'b0;
      q.ir <= '0;
      q.pc <= PC_RESET;
      q.acc <= ACC_RESET;
      q.nil <= 1'b0;
      q.shout <= 1'b0;
      q.take <= 1'b0;
      q.done <= 1'b0;
      q.unknown <= 1'b0;
      q.wr_en <= 1'b0;
      q.wr_addr <= '0;
      q.wr_data <= ACC_RESET;
      q.host_ack <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign instr_take = q.take;
  assign pc = q.pc;
  assign accumulator_reg = q.acc;
  assign result_nil_flag = q.nil;
  assign shift_out_bit = q.shout;
  assign icycle_done = q.done;
  assign unknown_instr = q.unknown;
  assign file_wr_en = q.wr_en;
  assign file_wr_addr = q.wr_addr;
  assign file_wr_data = q.wr_data;
  assign host_wr_ack = q.host_ack;
endmodule : incr_or_shift_core

// ==== incr_or_shift_checker.sv ====
`timescale 1ns/100ps
module incr_or_shift_checker
  import incr_or_shift_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [LATCH_W-1:0] program_counter_upper_latch,
  input wire logic instr_take,
  input wire logic [PC_W-1:0] pc,
  input wire logic result_nil_flag,
  input wire logic shift_out_bit,
  input wire logic icycle_done,
  input wire logic file_wr_en,
  input wire logic [DATA_W-1:0] file_wr_data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Opcode of the previous taken word; a skip may discard the next one
  logic [5:0] prev_opc_ff;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prev_opc_ff <= 6'h00;
    end else if (instr_take) begin
      prev_opc_ff <= $past(instr_word[13:8]);
    end
  end
  AST_DONE: assert property (instr_take |=> icycle_done)
    else $error("no cycle end after take");
  AST_JMP_PC: assert property (
    instr_take && $past(instr_word[13:11]) == OPC_JUMP &&
    prev_opc_ff != OPC_INC_SKIP |=>
    pc == {$past(program_counter_upper_latch[6:3]),
    $past(instr_word[10:0], 2)}) else $error("jump target wrong");
  AST_PC_INC: assert property (
    instr_take && $past(instr_word[13:11]) != OPC_JUMP |=>
    pc == $past(pc) + 15'h0001) else $error("pc not stepped");
  AST_JMP_FLAG: assert property (
    instr_take && $past(instr_word[13:11]) == OPC_JUMP |=>
    ($stable(result_nil_flag) && $stable(shift_out_bit)) [*3])
    else $error("jump changed flag");
  AST_SKIP_FLAG: assert property (
    instr_take && $past(instr_word[13:8]) == OPC_INC_SKIP |=>
    $stable(result_nil_flag) && $stable(shift_out_bit))
    else $error("skip increment changed flag");
  AST_NIL_WR: assert property (
    file_wr_en && $past(instr_word[13:8], 2) != OPC_INC_SKIP |->
    result_nil_flag == (file_wr_data == 8'h00))
    else $error("nil flag disagrees with result");
  AST_WR_END: assert property (file_wr_en |-> icycle_done)
    else $error("write outside cycle end");
  AST_SHL_LSB: assert property (
    file_wr_en && $past(instr_word[13:8], 2) == OPC_SHL |->
    !file_wr_data[0]) else $error("shift lsb not zero");
endmodule : incr_or_shift_checker
bind incr_or_shift_core incr_or_shift_checker incr_or_shift_checker_i (
  .clk_sys(clk_sys), .rstn(rstn), .instr_word(instr_word),
  .program_counter_upper_latch(program_counter_upper_latch),
  .instr_take(instr_take), .pc(pc), .result_nil_flag(result_nil_flag),
  .shift_out_bit(shift_out_bit), .icycle_done(icycle_done),
  .file_wr_en(file_wr_en), .file_wr_data(file_wr_data));

// ==== fetch_model.sv ====
`timescale 1ns/100ps
module fetch_model
  import incr_or_shift_pkg::*;
(
  input wire logic clk_sys,
  input wire logic instr_take,
  input wire logic host_wr_ack,
  output logic instr_valid,
  output logic [INSTR_W-1:0] instr_word,
  output logic host_wr_en,
  output logic [FILE_ADDR_W-1:0] host_wr_addr,
  output logic [DATA_W-1:0] host_wr_data
);
  initial begin
    instr_valid = 1'b0;
    instr_word = '0;
    host_wr_en = 1'b0;
    host_wr_addr = '0;
    host_wr_data = '0;
  end
  // Word held until taken; released lines show the inverse
  task automatic issue(input logic [INSTR_W-1:0] w, output bit ok);
    ok = 1'b0;
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr_word = w;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_sys);
      #1 ok = instr_take === 1'b1;
    end
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr_word = ~w;
  endtask : issue
  task automatic preload(input logic [6:0] a, input logic [7:0] d,
      output bit ok);
    ok = 1'b0;
    @(negedge clk_sys);
    host_wr_en = 1'b1;
    host_wr_addr = a;
    host_wr_data = d;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_sys);
      #1 ok = host_wr_ack === 1'b1;
    end
    @(negedge clk_sys);
    host_wr_en = 1'b0;
    host_wr_data = ~d;
  endtask : preload
endmodule : fetch_model

// ==== test_increment_or_shift_jump_exec.sv ====
`timescale 1ns/100ps
module test_increment_or_shift_jump_exec import incr_or_shift_pkg::*;;
  logic clk_sys;
  logic rstn;
  logic iv;
  logic [13:0] iw;
  logic [6:0] latch;
  logic hwe;
  logic [6:0] hwa;
  logic [7:0] hwd;
  logic take;
  logic [14:0] pc;
  logic [7:0] acc;
  logic nil;
  logic sh;
  logic done;
  logic wr;
  logic [6:0] wa;
  logic [7:0] wd;
  logic ack;
  logic unk;
  logic [14:0] pcx;
  int failures;
  int samples_checked;
  bit ok;
  incr_or_shift_core incr_or_shift_core_i (
    .clk_sys(clk_sys), .rstn(rstn), .instr_valid(iv), .instr_word(iw),
    .program_counter_upper_latch(latch), .host_wr_en(hwe),
    .host_wr_addr(hwa), .host_wr_data(hwd), .instr_take(take), .pc(pc),
    .accumulator_reg(acc), .result_nil_flag(nil), .shift_out_bit(sh),
    .icycle_done(done), .unknown_instr(unk), .file_wr_en(wr),
    .file_wr_addr(wa), .file_wr_data(wd), .host_wr_ack(ack));
  fetch_model fetch_model_i (
    .clk_sys(clk_sys), .instr_take(take), .host_wr_ack(ack),
    .instr_valid(iv), .instr_word(iw), .host_wr_en(hwe),
    .host_wr_addr(hwa), .host_wr_data(hwd));
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input logic [13:0] w);
    int i = 0;
    fetch_model_i.issue(w, ok);
    while (ok && done !== 1'b1 && i < 10) begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (!ok || done !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask : go
  // Expected flags in f: nil, shift-out, register write
  task automatic run(input logic [13:0] w, input logic [7:0] ea,
      input logic [2:0] f, input logic [7:0] ed);
    go(w);
    pcx = pcx + 15'h0001;
    chk("pc", 16'(pcx), 16'(pc));
    chk("acc", 16'(ea), 16'(acc));
    chk("nil", 16'(f[2]), 16'(nil));
    chk("shout", 16'(f[1]), 16'(sh));
    chk("wr_en", 16'(f[0]), 16'(wr));
    chk("unknown", 16'h0000, 16'(unk));
    if (f[0]) begin
      chk("wr_data", 16'(ed), 16'(wd));
      chk("wr_addr", 16'(w[6:0]), 16'(wa));
    end
  endtask : run
  task automatic t_reset();
    chk("pc", 16'h0000, 16'(pc));
    chk("acc", 16'h0000, 16'(acc));
    chk("nil", 16'h0000, 16'(nil));
    chk("shout", 16'h0000, 16'(sh));
  endtask : t_reset
  task automatic t_load();
    logic [7:0] v [4] = '{8'hff, 8'h80, 8'h0f, 8'hff};
    for (int i = 0; i < 4; i++) begin
      fetch_model_i.preload(7'(5 + i), v[i], ok);
      chk("ack", 16'h0001, 16'(ok));
    end
    fetch_model_i.preload(7'h7f, 8'h40, ok);
    chk("ack", 16'h0001, 16'(ok));
  endtask : t_load
  task automatic t_alu();
    run({OPC_OR_IMM, 8'h00}, 8'h00, 3'b100, 8'h00);
    run({OPC_OR_IMM, 8'h81}, 8'h81, 3'b000, 8'h00);
    run({OPC_INC, 1'b0, 7'h07}, 8'h10, 3'b000, 8'h00);
    run({OPC_INC, 1'b1, 7'h05}, 8'h10, 3'b101, 8'h00);
    run({OPC_SHL, 1'b0, 7'h06}, 8'h00, 3'b110, 8'h00);
    run({OPC_SHL, 1'b1, 7'h07}, 8'h00, 3'b001, 8'h1e);
    run({OPC_OR_OPND, 1'b0, 7'h07}, 8'h1e, 3'b000, 8'h00);
    run({OPC_OR_OPND, 1'b1, 7'h05}, 8'h1e, 3'b001, 8'h1e);
  endtask : t_alu
  task automatic t_skip();
    run({OPC_INC_SKIP, 1'b1, 7'h08}, 8'h1e, 3'b001, 8'h00);
    run({OPC_OR_IMM, 8'hff}, 8'h1e, 3'b000, 8'h00);
    run({OPC_INC_SKIP, 1'b0, 7'h07}, 8'h1f, 3'b000, 8'h00);
    run({OPC_OR_IMM, 8'h20}, 8'h3f, 3'b000, 8'h00);
  endtask : t_skip
  task automatic t_other();
    go(14'h0000);
    pcx = pcx + 15'h0001;
    chk("unknown", 16'h0001, 16'(unk));
    chk("pc", 16'(pcx), 16'(pc));
    chk("acc", 16'h003f, 16'(acc));
    chk("wr_en", 16'h0000, 16'(wr));
  endtask : t_other
  task automatic t_jump();
    go({OPC_JUMP, 11'h123});
    chk("pc", 16'({4'hb, 11'h123}), 16'(pc));
    chk("nil", 16'h0000, 16'(nil));
    chk("shout", 16'h0000, 16'(sh));
    @(posedge clk_sys);
    #1 chk("done", 16'h0000, 16'(done));
    @(posedge clk_sys);
    #1 chk("done", 16'h0001, 16'(done));
    chk("pc", 16'({4'hb, 11'h123}), 16'(pc));
    pcx = {4'hb, 11'h123};
    run({OPC_OR_OPND, 1'b0, 7'h7f}, 8'h7f, 3'b000, 8'h00);
  endtask : t_jump
  task automatic t_rerun();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    pcx = '0;
    t_reset();
    run({OPC_OR_IMM, 8'h00}, 8'h00, 3'b100, 8'h00);
  endtask : t_rerun
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    rstn = 1'b0;
    latch = 7'h5d;
    pcx = '0;
    failures = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_load();
    t_alu();
    t_skip();
    t_other();
    t_jump();
    t_rerun();
    print_verdict();
  end
endmodule : test_increment_or_shift_jump_exec
